// ### rtl/srs_select.v
// Speed reference and run command selection for the drive core.
// Assumes analog samples, presets and settings arrive on core_clk;
// contact terminals and keypad keys are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "srs_defines.vh"

// Summary of operation
// - Source zero: keypad-entered reference
// - Source one: reference from analog channels
// - Aux-ref mode: step two picks aux
// - Aux function zero adds both channels
// - Swap setting exchanges main and aux
// - Four presets plus one jog speed
// - Codes 3, 4, 6: steps, jog
// - Step bits pick presets one to four
// - Jog overrides both step commands
// - Step one: analog or preset one
// - Step two: aux analog or preset two
// - Code 69 under two-wire raises alarm
// - Run source zero: keypad keys only
// - Run source one: control terminals
// - Two-wire: forward/reverse while input held
// - Code 0 selects three-wire, direction input
// - Three-wire init: input three gives direction
// - Run pulse of 50 ms self-holds
module srs_select #(
  parameter [`SRS_HOLD_CNT_W-1:0] HOLD_CYCLES = `SRS_RUN_HOLD_CYCLES
) (
  input wire core_clk,
  input wire rst_n,
  input wire [1:0] reference_source_select,
  input wire [1:0] run_source_select,
  input wire [1:0] init_mode_select,
  input wire [4:0] aux_analog_function,
  input wire analog_channel_swap,
  input wire [`SRS_NUM_MFI*`SRS_CODE_W-1:0] input_function_select,
  input wire [`SRS_REF_W-1:0] analog_main_channel,
  input wire [`SRS_REF_W-1:0] analog_aux_channel,
  input wire [`SRS_REF_W-1:0] preset_reference_one,
  input wire [`SRS_REF_W-1:0] preset_reference_two,
  input wire [`SRS_REF_W-1:0] preset_reference_three,
  input wire [`SRS_REF_W-1:0] preset_reference_four,
  input wire [`SRS_REF_W-1:0] jog_reference,
  input wire forward_run_terminal,
  input wire reverse_run_terminal,
  input wire [`SRS_NUM_MFI-1:0] multi_input_terminal,
  input wire keypad_run_key,
  input wire keypad_stop_key,
  input wire keypad_dir_key,
  output wire [`SRS_REF_W-1:0] speed_reference,
  output wire [2:0] speed_step,
  output wire run_command,
  output wire run_reverse,
  output wire three_wire_mode,
  output wire setting_conflict_alarm
);

  localparam NSYNC = `SRS_NUM_MFI + 5;

  // Synchronised pins
  wire [NSYNC-1:0] pins_sync;
  wire fwd_s;
  wire rev_s;
  wire [`SRS_NUM_MFI-1:0] mfi_s;
  wire key_run_s;
  wire key_stop_s;
  wire key_dir_s;

  srs_sync #(
    .WIDTH(NSYNC)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({keypad_dir_key, keypad_stop_key, keypad_run_key,
               multi_input_terminal, reverse_run_terminal,
               forward_run_terminal}),
    .sync_out(pins_sync)
  );

  assign fwd_s = pins_sync[0];
  assign rev_s = pins_sync[1];
  assign mfi_s = pins_sync[`SRS_NUM_MFI+1:2];
  assign key_run_s = pins_sync[`SRS_NUM_MFI+2];
  assign key_stop_s = pins_sync[`SRS_NUM_MFI+3];
  assign key_dir_s = pins_sync[`SRS_NUM_MFI+4];

  // Per-terminal function decode
  wire [`SRS_NUM_MFI-1:0] is_step1;
  wire [`SRS_NUM_MFI-1:0] is_step2;
  wire [`SRS_NUM_MFI-1:0] is_jog;
  wire [`SRS_NUM_MFI-1:0] is_jog2;
  wire [`SRS_NUM_MFI-1:0] is_dir;

  genvar gi;
  generate
    for (gi = 0; gi < `SRS_NUM_MFI; gi = gi + 1) begin : g_mfi
      wire [`SRS_CODE_W-1:0] code;
      assign code = input_function_select[gi*`SRS_CODE_W +: `SRS_CODE_W];
      assign is_step1[gi] = (code == `SRS_FN_STEP_ONE);
      assign is_step2[gi] = (code == `SRS_FN_STEP_TWO);
      assign is_jog[gi] = (code == `SRS_FN_JOG);
      assign is_jog2[gi] = (code == `SRS_FN_JOG_TWO);
      assign is_dir[gi] = (code == `SRS_FN_FWD_REV);
    end
  endgenerate

  wire init_three;
  wire three_wire;
  wire step1_on;
  wire step2_on;
  wire jog_on;
  wire dir_rev;
  wire conflict;

  assign init_three = (init_mode_select == `SRS_INIT_THREE_WIRE);
  assign three_wire = init_three | (|is_dir);
  assign step1_on = |(is_step1 & mfi_s);
  assign step2_on = |(is_step2 & mfi_s);
  // Second jog input only counts once three-wire control is in force
  assign jog_on = |(is_jog & mfi_s) | (three_wire & |(is_jog2 & mfi_s));
  // After three-wire init the third multi-function input steers direction
  assign dir_rev = init_three ? mfi_s[`SRS_INIT3_DIR_SLOT]
                              : |(is_dir & mfi_s);
  assign conflict = (|is_jog2) & ~three_wire;

  // Analog channel combination
  wire [`SRS_REF_W-1:0] ana_master;
  wire [`SRS_REF_W-1:0] ana_aux;
  wire [`SRS_REF_W:0] ana_sum;
  wire [`SRS_REF_W-1:0] ana_sum_sat;
  wire aux_is_add;
  wire aux_is_ref;

  assign ana_master = analog_channel_swap ? analog_aux_channel
                                          : analog_main_channel;
  assign ana_aux = analog_channel_swap ? analog_main_channel
                                       : analog_aux_channel;
  assign ana_sum = {1'b0, ana_master} + {1'b0, ana_aux};
  // Saturate rather than wrap, so a large sum never drops to a low speed
  assign ana_sum_sat = ana_sum[`SRS_REF_W] ? {`SRS_REF_W{1'b1}}
                                           : ana_sum[`SRS_REF_W-1:0];
  assign aux_is_add = (aux_analog_function == `SRS_AUX_FN_ADD);
  assign aux_is_ref = (aux_analog_function == `SRS_AUX_FN_AUX_REF);

  // Reference selection
  reg [`SRS_REF_W-1:0] ref_nxt;
  reg [2:0] step_nxt;
  wire src_analog;

  assign src_analog = (reference_source_select == `SRS_REF_SRC_ANALOG);

  always @* begin
    ref_nxt = preset_reference_one;
    step_nxt = `SRS_STEP_ONE;
    if (jog_on) begin
      ref_nxt = jog_reference;
      step_nxt = `SRS_STEP_JOG;
    end else begin
      case ({step2_on, step1_on})
        2'b00: begin
          step_nxt = `SRS_STEP_ONE;
          if (src_analog) begin
            // Step one follows the analog master, plus aux in add mode
            ref_nxt = aux_is_add ? ana_sum_sat : ana_master;
          end else begin
            ref_nxt = preset_reference_one;
          end
        end
        2'b01: begin
          step_nxt = `SRS_STEP_TWO;
          if (src_analog && aux_is_ref) begin
            ref_nxt = ana_aux;
          end else begin
            ref_nxt = preset_reference_two;
          end
        end
        2'b10: begin
          step_nxt = `SRS_STEP_THREE;
          ref_nxt = preset_reference_three;
        end
        2'b11: begin
          step_nxt = `SRS_STEP_FOUR;
          ref_nxt = preset_reference_four;
        end
        default: begin
          step_nxt = `SRS_STEP_ONE;
          ref_nxt = preset_reference_one;
        end
      endcase
    end
  end

  // Keypad key edges
  reg key_run_d_r;
  reg key_stop_d_r;
  reg key_dir_d_r;
  wire key_run_rise;
  wire key_stop_rise;
  wire key_dir_rise;

  assign key_run_rise = key_run_s & ~key_run_d_r;
  assign key_stop_rise = key_stop_s & ~key_stop_d_r;
  assign key_dir_rise = key_dir_s & ~key_dir_d_r;

  // Three-wire run latch
  wire src_keypad;
  wire src_term;
  wire held_run;

  assign src_keypad = (run_source_select == `SRS_RUN_SRC_KEYPAD);
  assign src_term = (run_source_select == `SRS_RUN_SRC_TERMINAL);

  srs_run_latch #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_latch (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(src_term & three_wire),
    .run_pulse(fwd_s),
    .stop_closed(rev_s),
    .run_held(held_run)
  );

  // Keypad run state
  reg kp_run_r;
  reg kp_rev_r;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_run_d_r <= 1'b0;
      key_stop_d_r <= 1'b0;
      key_dir_d_r <= 1'b0;
      kp_run_r <= 1'b0;
      kp_rev_r <= 1'b0;
    end else begin
      key_run_d_r <= key_run_s;
      key_stop_d_r <= key_stop_s;
      key_dir_d_r <= key_dir_s;
      if (!src_keypad) begin
        // Keys are ignored and forgotten under terminal control
        kp_run_r <= 1'b0;
        kp_rev_r <= 1'b0;
      end else begin
        // Stop beats run when both keys rise together
        if (key_stop_rise) begin
          kp_run_r <= 1'b0;
        end else if (key_run_rise) begin
          kp_run_r <= 1'b1;
        end
        if (key_dir_rise) begin
          kp_rev_r <= ~kp_rev_r;
        end
      end
    end
  end

  // Run command selection
  reg run_nxt;
  reg rev_nxt;

  always @* begin
    run_nxt = 1'b0;
    rev_nxt = 1'b0;
    if (src_keypad) begin
      run_nxt = kp_run_r;
      rev_nxt = kp_rev_r;
    end else if (src_term) begin
      if (three_wire) begin
        run_nxt = held_run;
        rev_nxt = dir_rev;
      end else begin
        // Both inputs on is ambiguous and is taken as stop
        run_nxt = fwd_s ^ rev_s;
        rev_nxt = rev_s & ~fwd_s;
      end
    end else begin
      run_nxt = 1'b0;
      rev_nxt = 1'b0;
    end
  end

  // Output registers
  reg [`SRS_REF_W-1:0] speed_reference_r;
  reg [2:0] speed_step_r;
  reg run_command_r;
  reg run_reverse_r;
  reg three_wire_mode_r;
  reg setting_conflict_alarm_r;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_reference_r <= {`SRS_REF_W{1'b0}};
      speed_step_r <= `SRS_STEP_ONE;
      run_command_r <= 1'b0;
      run_reverse_r <= 1'b0;
      three_wire_mode_r <= 1'b0;
      setting_conflict_alarm_r <= 1'b0;
    end else begin
      speed_reference_r <= ref_nxt;
      speed_step_r <= step_nxt;
      // The alarm also holds the run off until the setting is fixed
      run_command_r <= run_nxt & ~conflict;
      // Direction holds its last value while stopped
      if (run_nxt) begin
        run_reverse_r <= rev_nxt;
      end
      three_wire_mode_r <= three_wire;
      setting_conflict_alarm_r <= conflict;
    end
  end

  assign speed_reference = speed_reference_r;
  assign speed_step = speed_step_r;
  assign run_command = run_command_r;
  assign run_reverse = run_reverse_r;
  assign three_wire_mode = three_wire_mode_r;
  assign setting_conflict_alarm = setting_conflict_alarm_r;

endmodule
`default_nettype wire

// ### include/srs_defines.vh
// Constants for the speed reference and run command selection block.
// Assumes a 200 MHz core clock; included by every file of the block except the synchroniser and the far-side model.
`ifndef SRS_DEFINES_VH
`define SRS_DEFINES_VH

// Data widths
`define SRS_REF_W 16
`define SRS_CODE_W 7
`define SRS_NUM_MFI 5
`define SRS_HOLD_CNT_W 24

// Reference source selector values
`define SRS_REF_SRC_KEYPAD 2'h0
`define SRS_REF_SRC_ANALOG 2'h1

// Run source selector values
`define SRS_RUN_SRC_KEYPAD 2'h0
`define SRS_RUN_SRC_TERMINAL 2'h1

// Auxiliary analog function selector values
`define SRS_AUX_FN_ADD 5'h00
`define SRS_AUX_FN_AUX_REF 5'h02
`define SRS_AUX_FN_UNUSED 5'h1F

// Multi-function input codes
`define SRS_FN_FWD_REV 7'h00
`define SRS_FN_STEP_ONE 7'h03
`define SRS_FN_STEP_TWO 7'h04
`define SRS_FN_JOG 7'h06
`define SRS_FN_JOG_TWO 7'h45

// Initialisation mode values
`define SRS_INIT_TWO_WIRE 2'h1
`define SRS_INIT_THREE_WIRE 2'h2

// Slot of the third-terminal input taken as direction after 3-wire init
`define SRS_INIT3_DIR_SLOT 2

// Speed step indices reported on the status port
`define SRS_STEP_ONE 3'h0
`define SRS_STEP_TWO 3'h1
`define SRS_STEP_THREE 3'h2
`define SRS_STEP_FOUR 3'h3
`define SRS_STEP_JOG 3'h4

// Least run pulse width in three-wire control
`define SRS_RUN_HOLD_MS 50
`define SRS_CLK_MHZ 200
// 50 ms of 200 MHz cycles, sized to the hold counter so nothing is cut
`define SRS_RUN_HOLD_CYCLES 24'h989680

`endif

// ### rtl/srs_sync.v
// Two-stage synchroniser for a group of contact and key inputs.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module srs_sync #(
  parameter WIDTH = 1
) (
  input wire core_clk,
  input wire rst_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta_r;
      reg stable_r;
      // The first stage feeds only the second one
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          stable_r <= 1'b0;
        end else begin
          meta_r <= async_in[gi];
          stable_r <= meta_r;
        end
      end
      assign sync_out[gi] = stable_r;
    end
  endgenerate

endmodule
`default_nettype wire

// ### rtl/srs_run_latch.v
// Three-wire run latch: qualifies the run pulse width and self-holds.
// Assumes synchronised terminal levels and a stop contact that is high when closed.
`timescale 1ns/1ps
`default_nettype none
`include "srs_defines.vh"

module srs_run_latch #(
  parameter [`SRS_HOLD_CNT_W-1:0] HOLD_CYCLES = `SRS_RUN_HOLD_CYCLES
) (
  input wire core_clk,
  input wire rst_n,
  input wire enable,
  input wire run_pulse,
  input wire stop_closed,
  output wire run_held
);

  reg [`SRS_HOLD_CNT_W-1:0] hold_cnt_r;
  reg run_held_r;
  wire pulse_long;

  assign pulse_long = (hold_cnt_r >= HOLD_CYCLES - 1'b1);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_r <= {`SRS_HOLD_CNT_W{1'b0}};
      run_held_r <= 1'b0;
    end else begin
      if (!enable || !run_pulse) begin
        hold_cnt_r <= {`SRS_HOLD_CNT_W{1'b0}};
      end else if (!pulse_long) begin
        hold_cnt_r <= hold_cnt_r + 1'b1;
      end
      // Opening stop wins over a run pulse still held
      if (!enable || !stop_closed) begin
        run_held_r <= 1'b0;
      end else if (run_pulse && pulse_long) begin
        run_held_r <= 1'b1;
      end
    end
  end

  assign run_held = run_held_r;

endmodule
`default_nettype wire

// ### sim/srs_properties.sv
// Checker for srs_select: port-level timing of reference and run selection.
// Assumes one core_clk domain; bound to every srs_select instance.
`timescale 1ns/1ps
`default_nettype none
`include "srs_defines.vh"
module srs_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] reference_source_select,
  input wire logic [1:0] run_source_select,
  input wire logic [4:0] aux_analog_function,
  input wire logic analog_channel_swap,
  input wire logic [`SRS_NUM_MFI*`SRS_CODE_W-1:0] input_function_select,
  input wire logic [`SRS_REF_W-1:0] analog_main_channel,
  input wire logic [`SRS_REF_W-1:0] preset_reference_one,
  input wire logic [`SRS_REF_W-1:0] preset_reference_three,
  input wire logic [`SRS_REF_W-1:0] preset_reference_four,
  input wire logic [`SRS_REF_W-1:0] jog_reference,
  input wire logic forward_run_terminal,
  input wire logic reverse_run_terminal,
  input wire logic [`SRS_REF_W-1:0] speed_reference,
  input wire logic [2:0] speed_step,
  input wire logic run_command,
  input wire logic run_reverse,
  input wire logic three_wire_mode,
  input wire logic setting_conflict_alarm
);
  wire two_wire;
  assign two_wire = run_source_select == `SRS_RUN_SRC_TERMINAL && !three_wire_mode
    && !setting_conflict_alarm;
  function automatic logic has_dir(input logic [34:0] f);
    has_dir = 1'h0;
    for (int i = 0; i < `SRS_NUM_MFI; i++)
      if (f[7*i +: 7] == `SRS_FN_FWD_REV) has_dir = 1'h1;
  endfunction
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Five samples cover the two sync flops and the output register
  sequence one_dir_s;
    (two_wire && (forward_run_terminal ^ reverse_run_terminal)
      && $stable(reverse_run_terminal))[*5];
  endsequence
  sequence both_on_s;
    (two_wire && forward_run_terminal && reverse_run_terminal)[*5];
  endsequence
  sequence stop_open_s;
    (run_source_select == `SRS_RUN_SRC_TERMINAL && three_wire_mode
      && !reverse_run_terminal)[*5];
  endsequence
  keypad_ref_a: assert property (speed_step == `SRS_STEP_ONE
    && $past(rst_n && reference_source_select == 2'h0)
    |-> speed_reference == $past(preset_reference_one)) else $error("keypad reference wrong");
  main_only_a: assert property (speed_step == `SRS_STEP_ONE && $past(rst_n
    && reference_source_select == 2'h1 && aux_analog_function == 5'h1F && !analog_channel_swap)
    |-> speed_reference == $past(analog_main_channel)) else $error("main channel not used");
  upper_steps_a: assert property ($past(rst_n) && speed_step inside {3'h2, 3'h3}
    |-> speed_reference == (speed_step == 3'h2 ? $past(preset_reference_three)
    : $past(preset_reference_four))) else $error("preset three or four wrong");
  jog_ref_a: assert property ($past(rst_n) && speed_step == `SRS_STEP_JOG
    |-> speed_reference == $past(jog_reference)) else $error("jog reference wrong");
  dir_code_a: assert property ($past(rst_n && has_dir(input_function_select))
    |-> three_wire_mode) else $error("direction code did not give three-wire");
  two_wire_a: assert property (one_dir_s
    |-> run_command && run_reverse == reverse_run_terminal) else $error("two-wire run wrong");
  both_on_a: assert property (both_on_s |-> !run_command)
    else $error("run with both inputs on");
  stop_open_a: assert property (stop_open_s |-> !run_command)
    else $error("run held with stop open");
  alarm_gate_a: assert property (setting_conflict_alarm
    |-> !run_command && !three_wire_mode) else $error("alarm with run or three-wire");
endmodule
bind srs_select srs_properties i_props (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .reference_source_select(reference_source_select),
  .run_source_select(run_source_select),
  .aux_analog_function(aux_analog_function),
  .analog_channel_swap(analog_channel_swap),
  .input_function_select(input_function_select),
  .analog_main_channel(analog_main_channel),
  .preset_reference_one(preset_reference_one),
  .preset_reference_three(preset_reference_three),
  .preset_reference_four(preset_reference_four),
  .jog_reference(jog_reference),
  .forward_run_terminal(forward_run_terminal),
  .reverse_run_terminal(reverse_run_terminal),
  .speed_reference(speed_reference),
  .speed_step(speed_step),
  .run_command(run_command),
  .run_reverse(run_reverse),
  .three_wire_mode(three_wire_mode),
  .setting_conflict_alarm(setting_conflict_alarm)
);
`default_nettype wire

// ### sim/srs_far_side.sv
// Far-side model: contact terminals and operator keys of srs_select.
// Assumes the bench calls its tasks; pins move 1 ns after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module srs_far_side (
  input wire logic core_clk,
  output var logic fwd,
  output var logic rev,
  output var logic [4:0] mi,
  output var logic [2:0] key
);
  initial begin
    fwd = 1'h0;
    rev = 1'h0;
    mi = 5'h00;
    key = 3'h0;
  end
  task automatic set_pins(input logic f, input logic r, input logic [4:0] m);
    @(posedge core_clk);
    #1;
    fwd = f;
    rev = r;
    mi = m;
  endtask
  // Held three cycles so the two-stage sync cannot miss the edge
  task automatic press(input int k);
    @(posedge core_clk);
    #1;
    key[k] = 1'h1;
    repeat (3) @(posedge core_clk);
    #1;
    key[k] = 1'h0;
  endtask
  // Width in cycles; a short one is only sent to be ignored
  task automatic pulse_run(input int n);
    @(posedge core_clk);
    #1;
    fwd = 1'h1;
    repeat (n) @(posedge core_clk);
    #1;
    fwd = 1'h0;
  endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
// Bench for srs_select: settings and pin sequences against expected results.
// Assumes srs_far_side drives the pins and the checker is bound to the design.
`timescale 1ns/1ps
`default_nettype none
`include "srs_defines.vh"
module tb;
  localparam [23:0] HOLD = 24'h000008;
  localparam [34:0] STD = {`SRS_FN_JOG, `SRS_FN_STEP_TWO, `SRS_FN_STEP_ONE, 7'h0A, 7'h0A};
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [1:0] ref_src = 2'h0;
  logic [1:0] run_src = 2'h1;
  logic [1:0] init_m = `SRS_INIT_TWO_WIRE;
  logic [4:0] aux_fn = 5'h1F;
  logic swap = 1'h0;
  logic [34:0] codes = STD;
  logic [15:0] pre [0:4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h0555};
  wire fwd, rev, run, run_rev, three_w, alarm;
  wire [4:0] mi;
  wire [2:0] key;
  wire [2:0] step;
  wire [15:0] sref;
  int n_mismatch = 0;
  int tests_run = 0;
  always #2.5 core_clk = ~core_clk;
  srs_far_side i_far (.core_clk(core_clk), .fwd(fwd), .rev(rev), .mi(mi), .key(key));
  srs_select #(.HOLD_CYCLES(HOLD)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .reference_source_select(ref_src), .run_source_select(run_src),
    .init_mode_select(init_m), .aux_analog_function(aux_fn), .analog_channel_swap(swap),
    .input_function_select(codes), .analog_main_channel(16'h1234),
    .analog_aux_channel(16'h0F00), .preset_reference_one(pre[0]),
    .preset_reference_two(pre[1]), .preset_reference_three(pre[2]),
    .preset_reference_four(pre[3]), .jog_reference(pre[4]), .forward_run_terminal(fwd),
    .reverse_run_terminal(rev), .multi_input_terminal(mi), .keypad_run_key(key[0]),
    .keypad_stop_key(key[1]), .keypad_dir_key(key[2]), .speed_reference(sref),
    .speed_step(step), .run_command(run), .run_reverse(run_rev),
    .three_wire_mode(three_w), .setting_conflict_alarm(alarm));
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_ref(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Pin results need up to four edges; five leaves margin
  task automatic settle;
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  task automatic ana(input logic [4:0] a, input logic s, input logic [4:0] m,
    input logic [15:0] e);
    aux_fn = a;
    swap = s;
    i_far.set_pins(1'h0, 1'h0, m);
    settle;
    chk_ref("ref", e, sref);
  endtask
  task automatic rc(input logic f, input logic r, input logic [4:0] m, input logic e);
    i_far.set_pins(f, r, m);
    settle;
    chk_bit("run", e, run);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    rst_n = 1'h1;
    settle;
    for (int s = 0; s < 4; s++) begin
      i_far.set_pins(1'h0, 1'h0, {1'h0, s[1:0], 2'h0});
      settle;
      chk_ref("ref", pre[s], sref);
      chk_ref("step", 16'(s), {13'h0, step});
    end
    i_far.set_pins(1'h0, 1'h0, 5'h1C);
    settle;
    chk_ref("ref", pre[4], sref);
    $display("test presets done");
    ref_src = `SRS_REF_SRC_ANALOG;
    ana(5'h1F, 1'h0, 5'h00, 16'h1234);
    ana(5'h00, 1'h0, 5'h00, 16'h2134);
    ana(5'h02, 1'h0, 5'h04, 16'h0F00);
    ana(5'h02, 1'h0, 5'h00, 16'h1234);
    ana(5'h02, 1'h1, 5'h00, 16'h0F00);
    ana(5'h02, 1'h1, 5'h04, 16'h1234);
    ana(5'h1F, 1'h0, 5'h04, pre[1]);
    $display("test analog done");
    rc(1'h1, 1'h0, 5'h00, 1'h1);
    chk_bit("dir", 1'h0, run_rev);
    rc(1'h0, 1'h1, 5'h00, 1'h1);
    chk_bit("dir", 1'h1, run_rev);
    rc(1'h1, 1'h1, 5'h00, 1'h0);
    rc(1'h0, 1'h0, 5'h00, 1'h0);
    $display("test two_wire done");
    run_src = `SRS_RUN_SRC_KEYPAD;
    rc(1'h1, 1'h0, 5'h00, 1'h0);
    i_far.press(0);
    settle;
    chk_bit("run", 1'h1, run);
    i_far.press(1);
    settle;
    chk_bit("run", 1'h0, run);
    i_far.press(2);
    i_far.press(0);
    settle;
    chk_bit("run", 1'h1, run);
    chk_bit("dir", 1'h1, run_rev);
    $display("test keypad done");
    i_far.set_pins(1'h0, 1'h1, 5'h00);
    run_src = `SRS_RUN_SRC_TERMINAL;
    codes = {STD[34:7], `SRS_FN_FWD_REV};
    settle;
    chk_bit("mode", 1'h1, three_w);
    i_far.pulse_run(HOLD - 3);
    settle;
    chk_bit("run", 1'h0, run);
    i_far.pulse_run(HOLD + 4);
    settle;
    chk_bit("run", 1'h1, run);
    rc(1'h0, 1'h1, 5'h01, 1'h1);
    chk_bit("dir", 1'h1, run_rev);
    rc(1'h0, 1'h0, 5'h01, 1'h0);
    $display("test three_wire done");
    codes = {`SRS_FN_JOG_TWO, STD[27:0]};
    settle;
    chk_bit("alarm", 1'h1, alarm);
    rc(1'h1, 1'h0, 5'h00, 1'h0);
    init_m = `SRS_INIT_THREE_WIRE;
    settle;
    chk_bit("alarm", 1'h0, alarm);
    chk_bit("mode", 1'h1, three_w);
    i_far.set_pins(1'h0, 1'h1, 5'h00);
    i_far.pulse_run(HOLD + 4);
    settle;
    chk_bit("run", 1'h1, run);
    chk_bit("dir", 1'h0, run_rev);
    rc(1'h0, 1'h1, 5'h04, 1'h1);
    chk_bit("dir", 1'h1, run_rev);
    $display("test init done");
    results;
  end
  // Tests take about 1.2 us; over fifteen times that means a hang
  initial begin
    #20000;
    n_mismatch++;
    results;
  end
endmodule
`default_nettype wire
